// [dvs_map.svh]
// Constants for the setpoint ramp controller: offsets, fields, resets, timing.
// Notes on behaviour
// R1: Narrow variant: 770 mV plus 10 mV/code.
// R2: Wide variant: 500 mV plus 10 mV/code.
// R3: Two select pins pick the active preset.
// R4: Active preset rewrite retargets after write completes.
// R5: Bit 7 picks power save or PWM.
// R6: Ramp code halves slope from 32 mV/us.
// R7: Narrow variant steps 10 mV at a time.
// R8: Wide variant steps 20 mV, final 10.
// R9: Forced PWM follows slope both directions.
// R10: Power save ramps down only if enabled.
// R11: Early warning flag above 120 C.
// R12: Shutdown above 150 C keeps registers.
// R13: Resume switching once cooled to 130 C.
// R14: Shutdown flag latched until host clears.
// R15: Supply lockout stops switching, resets registers.
// R16: Host interface works while supplies present.
// R17: Peak limit forces low side until clear.
// R18: Step interval equals step over slope.
// R19: Retarget mid-ramp continues from present setpoint.
`ifndef DVS_MAP_SVH
`define DVS_MAP_SVH
`define DVS_OFF_PRESET0 12'h000
`define DVS_OFF_PRESET1 12'h004
`define DVS_OFF_PRESET2 12'h008
`define DVS_OFF_PRESET3 12'h00c
`define DVS_OFF_CTRL 12'h010
`define DVS_OFF_STATUS 12'h014
`define DVS_OFF_IRQ_MASK 12'h018
`define DVS_OFF_SETPOINT 12'h01c
`define DVS_MODE_BIT 7
`define DVS_CTRL_RAMP_LSB 0
`define DVS_CTRL_RAMP_DOWN_IN_PULSE_SKIP_BIT 3
`define DVS_RST_PRESET 8'h00
`define DVS_RST_CTRL 8'h00
`define DVS_NARROW_BASE_MV 770
`define DVS_WIDE_BASE_MV 500
`define DVS_CODE_STEP_MV 10
`define DVS_FAST_SLOPE_MV_PER_US 32
`define DVS_CLK_MHZ 200
// Cycles per 10 mV at the fastest code: 10/32 us * 200 MHz = 62.5, round up.
`define DVS_STEP10_CYCLES ((`DVS_CODE_STEP_MV * `DVS_CLK_MHZ + \
   `DVS_FAST_SLOPE_MV_PER_US - 1) / `DVS_FAST_SLOPE_MV_PER_US)
`endif

// [dvs_pkg.sv]
// Types shared by the setpoint ramp controller.
package dvs_pkg;
   // Live thermal and current-limit flags after synchronisation.
   typedef struct packed {
      logic over_120;
      logic over_150;
      logic above_130;
      logic hs_peak_limit;
      logic ls_over_limit;
   } dvs_sense_t;
   // Gate drive outputs.
   typedef struct packed {
      logic hs_on;
      logic ls_on;
      logic stage_enable;
      logic forced_pwm;
      logic active_pulldown;
   } dvs_drive_t;
   // Ramp sequencer states.
   typedef enum logic [1:0] {dvs_idle, dvs_wait, dvs_step} dvs_ramp_state_t;
endpackage

// [dvs_sync3.sv]
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
module dvs_sync3 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_reg; // Metastability catcher, read only by s2.
   logic [WIDTH-1:0] s2_reg; // Second stage.
   logic [WIDTH-1:0] s3_reg; // Third stage.
   genvar i;
   // Shift pins through three flops.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   // A bit changes only when the second and third stages agree.
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               dout[i] <= 1'b0;
            end else if (s2_reg[i] == s3_reg[i]) begin
               dout[i] <= s3_reg[i];
            end
         end
      end
   endgenerate
endmodule

// [dvs_top.sv]
// Setpoint ramp controller: presets, ramp sequencer, thermal and limits.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "dvs_map.svh"
module dvs_top #(
   parameter bit WIDE = 1'b0,
   parameter int STEP10_CYCLES = `DVS_STEP10_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic preset_select_lsb,
   input wire logic preset_select_msb,
   input wire logic analog_supply_input_ok,
   input wire logic logic_supply_ok,
   input wire logic over_120_pin,
   input wire logic over_150_pin,
   input wire logic above_130_pin,
   input wire logic hs_peak_limit_pin,
   input wire logic ls_over_limit_pin,
   input wire logic pwm_hs_request,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic [10:0] setpoint_mv,
   output logic step_strobe,
   output dvs_pkg::dvs_drive_t drive
);
   import dvs_pkg::*;

   logic [6:0] sync_out; // Synchronised pins.
   logic [1:0] sel; // Active preset index.
   dvs_sense_t sense; // Synchronised sensor flags.
   logic supplies_ok; // Both supplies present.
   logic core_resetn; // Register reset including supply lockout.
   logic [7:0] preset_reg [4]; // Preset storage.
   logic [7:0] ctrl_reg; // Ramp code and ramp-in-PFM bit.
   logic [1:0] status_reg; // Sticky events: 0 early warning, 1 shutdown.
   logic [1:0] mask_reg; // Interrupt mask, one enables.
   logic shutdown_reg; // Power stage held off for temperature.
   logic ls_hold_reg; // Low side forced on after peak limit.
   logic [6:0] cur_code_reg; // Present setpoint in 10 mV codes.
   logic [6:0] target_code; // Code of the active preset.
   logic [17:0] cnt_reg; // Step interval counter.
   logic [17:0] interval; // Cycles per step at current slope.
   logic [2:0] ramp_code; // Ramp rate code.
   logic mode_pwm; // Active preset in forced PWM.
   logic going_down; // Target below present setpoint.
   logic paced; // Sequencer must pace this direction.
   logic [6:0] diff; // Distance to target.
   logic [6:0] step_size; // Codes per step.
   logic wr_en; // APB write takes effect.
   logic rd_en; // APB read takes effect.
   logic hit; // Address is mapped.
   dvs_ramp_state_t state_reg; // Sequencer state.

   // Select and comparator pins cross through the three-flop filter; pwm_hs_request goes straight in.
   dvs_sync3 #(.WIDTH(7)) u_sync (
      .clk(clk),
      .resetn(resetn),
      .din({preset_select_msb, preset_select_lsb, over_120_pin,
            over_150_pin, above_130_pin, hs_peak_limit_pin,
            ls_over_limit_pin}),
      .dout(sync_out)
   );

   // The supply-good signals are treated as already clean levels.
   assign sel = sync_out[6:5]; // [R3]
   assign sense = dvs_sense_t'(sync_out[4:0]);
   assign supplies_ok = analog_supply_input_ok & logic_supply_ok;
   // A lockout of either supply clears every register but the pin synchroniser; the gating is
   // combinational so the clear is immediate, at the cost of a reset
   // glitch risk that the analog side must keep clean.
   assign core_resetn = resetn & supplies_ok; // [R15]

   // APB decode; the slave answers in the access cycle, no wait states.
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite; // [R16]
   assign rd_en = psel & penable & ~pwrite;
   always_comb begin
      unique case (paddr)
         `DVS_OFF_PRESET0, `DVS_OFF_PRESET1, `DVS_OFF_PRESET2,
         `DVS_OFF_PRESET3, `DVS_OFF_CTRL, `DVS_OFF_STATUS,
         `DVS_OFF_IRQ_MASK, `DVS_OFF_SETPOINT: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit;

   // Preset registers; a write lands at once, so a rewrite of the active
   // preset retargets the ramp from the cycle after the access. [R4] [R5]
   genvar p;
   generate
      for (p = 0; p < 4; p++) begin : g_preset
         always_ff @(posedge clk or negedge core_resetn) begin
            if (!core_resetn) begin
               preset_reg[p] <= `DVS_RST_PRESET;
            end else if (wr_en && pstrb[0] &&
                         paddr == 12'(p * 4)) begin
               preset_reg[p] <= pwdata[7:0];
            end
         end
      end
   endgenerate

   // Global control: ramp rate code and ramp-in-PFM enable.
   always_ff @(posedge clk or negedge core_resetn) begin
      if (!core_resetn) begin
         ctrl_reg <= `DVS_RST_CTRL;
      end else if (wr_en && pstrb[0] && paddr == `DVS_OFF_CTRL) begin
         ctrl_reg <= {4'h0, pwdata[3:0]};
      end
   end

   // Interrupt mask.
   always_ff @(posedge clk or negedge core_resetn) begin
      if (!core_resetn) begin
         mask_reg <= 2'h0;
      end else if (wr_en && pstrb[0] && paddr == `DVS_OFF_IRQ_MASK) begin
         mask_reg <= pwdata[1:0];
      end
   end

   // Sticky status; a read clears, but a new event in the same cycle wins.
   always_ff @(posedge clk or negedge core_resetn) begin
      if (!core_resetn) begin
         status_reg <= 2'h0;
      end else begin
         status_reg <= ((rd_en && paddr == `DVS_OFF_STATUS) ?
                        2'h0 : status_reg) |
                       {sense.over_150, sense.over_120}; // [R11] [R14]
      end
   end
   assign irq = |(status_reg & mask_reg);

   // Read data is registered at the end of the setup phase, for use in the access cycle.
   always_ff @(posedge clk or negedge core_resetn) begin
      if (!core_resetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `DVS_OFF_PRESET0: prdata <= {24'h0, preset_reg[0]};
            `DVS_OFF_PRESET1: prdata <= {24'h0, preset_reg[1]};
            `DVS_OFF_PRESET2: prdata <= {24'h0, preset_reg[2]};
            `DVS_OFF_PRESET3: prdata <= {24'h0, preset_reg[3]};
            `DVS_OFF_CTRL: prdata <= {24'h0, ctrl_reg};
            `DVS_OFF_STATUS: prdata <= {28'h0, sense.over_120,
                                        shutdown_reg, 2'h0} |
                                       {30'h0, status_reg};
            `DVS_OFF_IRQ_MASK: prdata <= {30'h0, mask_reg};
            `DVS_OFF_SETPOINT: prdata <= {21'h0, setpoint_mv};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Thermal shutdown with hysteresis; registers stay intact meanwhile.
   always_ff @(posedge clk or negedge core_resetn) begin
      if (!core_resetn) begin
         shutdown_reg <= 1'b0;
      end else if (sense.over_150) begin
         shutdown_reg <= 1'b1; // [R12]
      end else if (!sense.above_130) begin
         shutdown_reg <= 1'b0; // [R13]
      end
   end

   // Active preset decode.
   assign ramp_code = ctrl_reg[2:0];
   assign mode_pwm = preset_reg[sel][`DVS_MODE_BIT]; // [R5]
   assign target_code = WIDE ? preset_reg[sel][6:0] :
                        {1'b0, preset_reg[sel][5:0]};
   assign going_down = target_code < cur_code_reg;
   assign diff = going_down ? 7'(cur_code_reg - target_code) :
                 7'(target_code - cur_code_reg);
   // Wide variant takes double steps, single when one code remains.
   assign step_size = (WIDE && diff >= 7'h02) ? 7'h02 : 7'h01; // [R8] [R7]
   // Interval scales with step size and doubles per code. [R6] [R18]
   assign interval = 18'((STEP10_CYCLES << ramp_code) *
                         ((WIDE && diff >= 7'h02) ? 2 : 1));
   // Downward pacing in power save only with the ramp-in-PFM bit.
   assign paced = !going_down || mode_pwm ||
                  ctrl_reg[`DVS_CTRL_RAMP_DOWN_IN_PULSE_SKIP_BIT]; // [R9] [R10]

   // Ramp sequencer: wait one interval when paced, then take one step toward target.
   always_ff @(posedge clk or negedge core_resetn) begin
      if (!core_resetn) begin
         state_reg <= dvs_idle;
         cnt_reg <= 18'h0;
         cur_code_reg <= 7'h00;
      end else begin
         unique case (state_reg)
            dvs_idle: begin
               cnt_reg <= 18'h0;
               if (diff != 7'h00) begin
                  state_reg <= paced ? dvs_wait : dvs_step;
               end
            end
            dvs_wait: begin
               // A target change mid-wait keeps the present code. [R19]
               if (diff == 7'h00) begin
                  state_reg <= dvs_idle;
               end else if (!paced || cnt_reg + 18'h1 >= interval) begin
                  state_reg <= dvs_step;
               end else begin
                  cnt_reg <= cnt_reg + 18'h1;
               end
            end
            dvs_step: begin
               cnt_reg <= 18'h0;
               if (diff != 7'h00) begin
                  cur_code_reg <= going_down ?
                                  7'(cur_code_reg - step_size) :
                                  7'(cur_code_reg + step_size); // [R19]
               end
               state_reg <= dvs_idle;
            end
            default: state_reg <= dvs_idle;
         endcase
      end
   end

   // Setpoint in millivolts, registered. [R1] [R2]
   always_ff @(posedge clk or negedge core_resetn) begin
      if (!core_resetn) begin
         setpoint_mv <= WIDE ? 11'(`DVS_WIDE_BASE_MV) :
                        11'(`DVS_NARROW_BASE_MV);
         step_strobe <= 1'b0;
      end else begin
         setpoint_mv <= 11'((WIDE ? `DVS_WIDE_BASE_MV :
                             `DVS_NARROW_BASE_MV) +
                            `DVS_CODE_STEP_MV * cur_code_reg);
         step_strobe <= (state_reg == dvs_step);
      end
   end

   // Peak current limit latches the low side on until the low-side over-limit flag drops. [R17]
   always_ff @(posedge clk or negedge core_resetn) begin
      if (!core_resetn) begin
         ls_hold_reg <= 1'b0;
      end else if (sense.hs_peak_limit) begin
         ls_hold_reg <= 1'b1;
      end else if (!sense.ls_over_limit) begin
         ls_hold_reg <= 1'b0;
      end
   end

   // Gate drive, registered; stage off in lockout or shutdown. [R12] [R15]
   always_ff @(posedge clk or negedge core_resetn) begin
      if (!core_resetn) begin
         drive <= '0;
      end else begin
         drive.stage_enable <= ~shutdown_reg;
         drive.forced_pwm <= mode_pwm;
         drive.active_pulldown <= going_down & paced;
         drive.hs_on <= ~shutdown_reg & pwm_hs_request &
                        ~ls_hold_reg & ~sense.hs_peak_limit; // [R17]
         drive.ls_on <= ~shutdown_reg &
                        (ls_hold_reg | sense.hs_peak_limit |
                         ~pwm_hs_request);
      end
   end
endmodule

// [dvs_checker_asserts.sv]
// Port checker for the setpoint ramp controller, bound into its top module.
`timescale 1ns/1ps
module dvs_checker #(
   parameter bit WIDE = 1'b0,
   parameter int STEP10_CYCLES = 2
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic analog_supply_input_ok,
   input wire logic logic_supply_ok,
   input wire logic over_150_pin,
   input wire logic hs_peak_limit_pin,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [10:0] setpoint_mv,
   input wire logic step_strobe,
   input wire dvs_pkg::dvs_drive_t drive
);
   import dvs_pkg::*;
   // Either supply dropping clears the registers just like the reset pin.
   wire logic live = resetn & analog_supply_input_ok & logic_supply_ok;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!live);
   // Comparator inputs held long enough to cross the pin filter.
   sequence hot_s; over_150_pin [*8]; endsequence
   sequence peak_s; hs_peak_limit_pin [*8]; endsequence
   // The legal span and step depend on which variant is built.
   a_range_held: assert property (
      WIDE ? (setpoint_mv >= 11'h1f4 && setpoint_mv <= 11'h6ea) :
      (setpoint_mv >= 11'h302 && setpoint_mv <= 11'h578))
      else $error("setpoint outside the configured range");
   a_step_ten: assert property ($changed(setpoint_mv) |->
      setpoint_mv == $past(setpoint_mv) + 11'h00a ||
      setpoint_mv == $past(setpoint_mv) - 11'h00a ||
      (WIDE && (setpoint_mv == $past(setpoint_mv) + 11'h014 ||
                setpoint_mv == $past(setpoint_mv) - 11'h014)))
      else $error("setpoint moved by other than one step");
   a_pwm_paced: assert property (
      $changed(setpoint_mv) && drive.forced_pwm |=> $stable(setpoint_mv) [*2])
      else $error("paced steps came too close");
   a_step_marked: assert property (
      $changed(setpoint_mv) |-> step_strobe || $past(step_strobe))
      else $error("setpoint moved without a step strobe");
   a_hot_off: assert property (hot_s |-> !drive.stage_enable &&
      !drive.hs_on) else $error("power stage on while overheated");
   a_peak_cut: assert property (peak_s |-> !drive.hs_on)
      else $error("high side on during peak limit");
   a_lockout_off: assert property (disable iff (!resetn)
      !analog_supply_input_ok |-> drive == '0)
      else $error("drive active in supply lockout");
   a_bad_addr: assert property (
      psel && penable && paddr >= 12'h020 |-> pslverr && pready)
      else $error("unmapped access not refused");
endmodule
bind dvs_top dvs_checker #(.WIDE(WIDE), .STEP10_CYCLES(STEP10_CYCLES)) i_chk (
   .clk, .resetn, .analog_supply_input_ok, .logic_supply_ok, .over_150_pin,
   .hs_peak_limit_pin, .psel, .penable, .paddr, .pready, .pslverr,
   .setpoint_mv, .step_strobe, .drive);

// [dvs_host_model.sv]
// Host model: the processor side that programs presets over the bus.
`timescale 1ns/1ps
module dvs_host_model (
   input wire logic clk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb
);
   // The bus idles low until the first request.
   initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   // One transfer, held unchanged until pready is sampled high.
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic err,
      output bit hung);
      int n;
      n = 0;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hf};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // A slave that never answers must not hang the run.
      while (pready !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      hung = (n >= 40);
      q = prdata; // Reading status is how the host clears flags.
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
endmodule

// [dvs_setpoint_ramp_control_test.sv]
// Self-checking bench for the setpoint ramp controller.
`timescale 1ns/1ps
module dvs_setpoint_ramp_control_test;
   import dvs_pkg::*;
   localparam int STEP = 2;
   logic clk, resetn, preset_select_lsb, preset_select_msb, pwm_hs_request;
   logic analog_supply_input_ok, logic_supply_ok, over_120_pin, over_150_pin;
   logic above_130_pin, hs_peak_limit_pin, ls_over_limit_pin;
   logic psel, penable, pwrite, pready, pslverr, irq, step_strobe, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   logic [10:0] setpoint_mv;
   logic [6:0] c;
   dvs_drive_t drive;
   bit hung;
   int n_errors, compares, n;
   dvs_top #(.WIDE(1'b0), .STEP10_CYCLES(STEP)) i_dut (.clk, .resetn,
      .preset_select_lsb, .preset_select_msb, .analog_supply_input_ok,
      .logic_supply_ok, .over_120_pin, .over_150_pin, .above_130_pin,
      .hs_peak_limit_pin, .ls_over_limit_pin, .pwm_hs_request, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .irq, .setpoint_mv, .step_strobe, .drive);
   dvs_host_model i_host (.clk, .pready, .pslverr, .prdata, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Expected millivolts for a narrow-range code.
   function automatic logic [10:0] mv(input int code);
      return 11'(770 + 10 * code);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out();
      if (n_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic acc(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      i_host.xfer(w, a, d, q, err, hung);
      if (hung) begin
         n_errors++;
         close_out();
      end
   endtask
   // Waits, bounded, for the setpoint to reach t; n returns the cycles.
   task automatic wait_sp(input logic [10:0] t, output int n);
      n = 0;
      while (setpoint_mv !== t && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk("setpoint", t, setpoint_mv);
      if (n >= 3000) close_out();
   endtask
   // Lets comparator pins cross the input filter.
   task automatic settle();
      repeat (8) @(posedge clk);
   endtask
   initial begin
      {preset_select_lsb, preset_select_msb, pwm_hs_request, resetn} = '0;
      {over_120_pin, over_150_pin, above_130_pin} = '0;
      {hs_peak_limit_pin, ls_over_limit_pin} = '0;
      {analog_supply_input_ok, logic_supply_ok} = 2'b11;
      void'($urandom(63078));
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      settle();
      for (int i = 0; i < 8; i++) begin
         acc(1'b0, 12'(4 * i), 32'h0);
         chk("reset value", (i == 7) ? 32'h302 : 32'h0, q);
      end
      acc(1'b0, 12'h020, 32'h0);
      chk("unmapped error", 1'b1, err);
      // Top code first, then random codes, each preset in forced PWM.
      for (int p = 0; p < 4; p++) begin
         c = (p == 0) ? 7'h3f : 7'($urandom_range(63));
         acc(1'b1, 12'(4 * p), {24'h0, 2'b10, c[5:0]});
         {preset_select_msb, preset_select_lsb} <= 2'(p);
         wait_sp(mv(c), n);
         chk("forced mode", 1'b1, drive.forced_pwm);
      end
      acc(1'b1, 12'h010, 32'h0);
      acc(1'b1, 12'h00c, 32'h80);
      wait_sp(mv(0), n);
      // Two steps at every slope code; the interval doubles per code.
      for (int r = 0; r < 8; r++) begin
         acc(1'b1, 12'h010, 32'(r));
         acc(1'b1, 12'h00c, 32'(8'h80 + 2 * (r + 1)));
         wait_sp(mv(2 * (r + 1)), n);
         chk("ramp time", 1'b1, n >= 2 * (STEP << r) &&
            n <= 2 * ((STEP << r) + 8) + 16);
      end
      acc(1'b1, 12'h010, 32'h3);
      acc(1'b1, 12'h00c, 32'hbf);
      repeat (100) @(posedge clk);
      acc(1'b1, 12'h00c, 32'h85);
      chk("no jump", 1'b1, setpoint_mv > mv(16));
      wait_sp(mv(5), n);
      acc(1'b1, 12'h010, 32'h7);
      acc(1'b1, 12'h00c, 32'h0);
      wait_sp(mv(0), n);
      chk("free fall", 1'b1, n < 200);
      chk("power save", 1'b0, drive.forced_pwm);
      acc(1'b1, 12'h00c, 32'h5);
      wait_sp(mv(5), n);
      chk("paced rise", 1'b1, n >= 5 * (STEP << 7));
      acc(1'b1, 12'h010, 32'hf);
      acc(1'b1, 12'h00c, 32'h0);
      repeat (3) @(posedge clk);
      chk("pulldown", 1'b1, drive.active_pulldown);
      wait_sp(mv(0), n);
      chk("paced fall", 1'b1, n >= 5 * (STEP << 7));
      // Warning masked, shutdown raises the interrupt until read.
      acc(1'b1, 12'h018, 32'h2);
      over_120_pin <= 1'b1;
      settle();
      chk("masked irq", 1'b0, irq);
      {over_150_pin, above_130_pin} <= 2'b11;
      settle();
      chk("shutdown stage", 1'b0, drive.stage_enable);
      chk("shutdown irq", 1'b1, irq);
      {over_150_pin, over_120_pin} <= 2'b00;
      settle();
      chk("hysteresis", 1'b0, drive.stage_enable);
      acc(1'b0, 12'h014, 32'h0);
      chk("sticky flags", 2'b11, q[1:0]);
      acc(1'b0, 12'h010, 32'h0);
      chk("kept ctrl", 32'hf, q);
      acc(1'b0, 12'h014, 32'h0);
      chk("flags cleared", 2'b00, q[1:0]);
      chk("irq cleared", 1'b0, irq);
      above_130_pin <= 1'b0;
      settle();
      chk("resumed", 1'b1, drive.stage_enable);
      {pwm_hs_request, hs_peak_limit_pin, ls_over_limit_pin} <= 3'b111;
      settle();
      chk("peak cut", 2'b01, {drive.hs_on, drive.ls_on});
      hs_peak_limit_pin <= 1'b0;
      settle();
      chk("low side held", 2'b01, {drive.hs_on, drive.ls_on});
      ls_over_limit_pin <= 1'b0;
      settle();
      chk("high side back", 2'b10, {drive.hs_on, drive.ls_on});
      for (int s = 0; s < 2; s++) begin
         acc(1'b1, 12'h000, 32'h11);
         if (s == 0) analog_supply_input_ok <= 1'b0;
         else logic_supply_ok <= 1'b0;
         repeat (2) @(posedge clk);
         chk("lockout drive", 32'h0, 32'(drive));
         {analog_supply_input_ok, logic_supply_ok} <= 2'b11;
         acc(1'b0, 12'h000, 32'h0);
         chk("lockout preset", 32'h0, q);
      end
      close_out();
   end
endmodule
